// ===== hdl/clk_switch_pkg.sv
// Shared constants and types for the system clock source switch.
package clk_switch_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 40;
	localparam int CNT_W = 16;
	localparam int SETTLE_NS = 2000;
	localparam logic [CNT_W-1:0] SETTLE_CYC = CNT_W'((SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int PLL_LOCK_NS = 2000000;
	localparam int PLL_LOCK_CYC = (PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WARMUP_NS = 1000;
	localparam int WARMUP_CYC = (WARMUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0] WAKE_EXT_EDGES = 2'h2;
	localparam logic [1:0] SWITCH_EDGES = 2'h1;
	localparam logic [1:0] BOOT_WAIT = 2'h2;

	// ----------------------------------------------------------------
	// Register map and fields
	// ----------------------------------------------------------------
	localparam logic [3:0] OSC_CTRL_ADDR = 4'h0;
	localparam logic [3:0] STATUS_ADDR = 4'h4;
	localparam int SEL_LSB = 0;
	localparam int SEL_MSB = 1;
	localparam int FREQ_LSB = 3;
	localparam int FREQ_MSB = 6;
	localparam int ST_SRC_LSB = 0;
	localparam int ST_SRC_MSB = 2;
	localparam int ST_BUSY = 3;
	localparam int ST_CFG_LSB = 4;
	localparam int ST_CFG_MSB = 5;
	localparam int ST_PLL = 6;

	// ----------------------------------------------------------------
	// Encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] CFG_EXT_LOW = 2'h0;
	localparam logic [1:0] CFG_EXT_MED = 2'h1;
	localparam logic [1:0] CFG_EXT_HIGH = 2'h2;
	localparam logic [1:0] CFG_INT_OSC = 2'h3;
	localparam logic [3:0] FREQ_LF = 4'h0;
	localparam logic [3:0] FREQ_MF_MAX = 4'h7;
	localparam logic [3:0] FREQ_HF_TOP = 4'hd;
	localparam int DIV_W = 12;

	typedef enum logic [2:0] {SRC_EXT, SRC_LF, SRC_MF, SRC_HF, SRC_PLL} src_t;

endpackage

// ===== hdl/pin_sync.sv
// Two-stage synchroniser for pins and free-running oscillator inputs.
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] sync_r;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= din;
			sync_r <= meta_r;
		end
	end

	assign dout = sync_r;
endmodule

// ===== hdl/switch_if.sv
// Handshake between the switch controller and its stabilisation timer.
`timescale 1ns/1ps
interface switch_if;
	logic start;
	logic use_time;
	logic [clk_switch_pkg::CNT_W-1:0] cycles;
	logic [1:0] old_edges;
	logic [1:0] new_edges;
	logic old_rise;
	logic new_rise;
	logic done;
	modport ctrl(output start, use_time, cycles, old_edges, new_edges, old_rise, new_rise,
		input done);
	modport timer(input start, use_time, cycles, old_edges, new_edges, old_rise, new_rise,
		output done);
endinterface

// ===== hdl/switch_timer.sv
// Stabilisation delay: a cycle count, or edges of the old then the new clock.
`timescale 1ns/1ps
module switch_timer (
	input wire logic clk,
	input wire logic reset_n,
	switch_if.timer sw
);
	typedef enum logic [1:0] {T_IDLE, T_TIME, T_OLD, T_NEW} tstate_t;
	tstate_t st_r, st_nxt;
	logic [clk_switch_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
	logic done_r, done_nxt;

	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		done_nxt = 1'b0;
		case (st_r)
			T_IDLE: begin
				if (sw.start && sw.use_time) begin
					cnt_nxt = sw.cycles;
					st_nxt = T_TIME;
				end else if (sw.start) begin
					cnt_nxt = clk_switch_pkg::CNT_W'(sw.old_edges);
					st_nxt = T_OLD;
				end
			end
			T_TIME: begin
				if (cnt_r <= clk_switch_pkg::CNT_W'(1)) begin
					done_nxt = 1'b1;
					st_nxt = T_IDLE;
				end else begin
					cnt_nxt = cnt_r - clk_switch_pkg::CNT_W'(1);
				end
			end
			T_OLD: begin
				if (cnt_r == '0) begin
					cnt_nxt = clk_switch_pkg::CNT_W'(sw.new_edges);
					st_nxt = T_NEW;
				end else if (sw.old_rise) begin
					cnt_nxt = cnt_r - clk_switch_pkg::CNT_W'(1);
				end
			end
			T_NEW: begin
				if (cnt_r == '0) begin
					done_nxt = 1'b1;
					st_nxt = T_IDLE;
				end else if (sw.new_rise) begin
					cnt_nxt = cnt_r - clk_switch_pkg::CNT_W'(1);
				end
			end
			default: st_nxt = T_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= T_IDLE;
			cnt_r <= '0;
			done_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			done_r <= done_nxt;
		end
	end

	assign sw.done = done_r;

	a_settle_exact: assert property (@(posedge clk) disable iff (!reset_n)
		sw.start && sw.use_time && sw.cycles == 16'd50 |-> ##51 sw.done)
		else $error("settle delay not 50 cycles");
	a_time_quiet: assert property (@(posedge clk) disable iff (!reset_n)
		sw.start && sw.use_time |=> !sw.done [*8])
		else $error("timed delay ended too early");
	a_edge_needed: assert property (@(posedge clk) disable iff (!reset_n)
		st_r == T_NEW && cnt_r != '0 |=> !sw.done)
		else $error("switch done before new clock edges");
endmodule

// ===== hdl/system_clock_source_switch.sv
// System clock source selection with stabilised, glitch-free switching.
`timescale 1ns/1ps
module system_clock_source_switch #(
	parameter int PLL_LOCK_CYCLES = clk_switch_pkg::PLL_LOCK_CYC,
	parameter int WARMUP_CYCLES = clk_switch_pkg::WARMUP_CYC
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [1:0] cfg_osc_select,
	input wire logic ext_clk_pin,
	input wire logic low_freq_osc_in,
	input wire logic high_freq_osc_in,
	input wire logic sleep,
	input wire logic [3:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	output logic sys_clk,
	output logic [1:0] ext_power_mode,
	output logic [2:0] active_source,
	output logic switch_busy,
	output logic pll_enable
);
	typedef enum logic [2:0] {ST_BOOT, ST_RUN, ST_WAIT, ST_SWAP, ST_SLEEP} state_t;

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	function automatic clk_switch_pkg::src_t class_of(input logic [3:0] code);
		if (code == clk_switch_pkg::FREQ_LF)
			return clk_switch_pkg::SRC_LF;
		else if (code <= clk_switch_pkg::FREQ_MF_MAX)
			return clk_switch_pkg::SRC_MF;
		else if (code <= clk_switch_pkg::FREQ_HF_TOP)
			return clk_switch_pkg::SRC_HF;
		return clk_switch_pkg::SRC_PLL;
	endfunction

	// Select 01 has no defined meaning and behaves like 00.
	function automatic clk_switch_pkg::src_t pick_src(input logic [1:0] sel,
		input logic [1:0] cfg, input logic [3:0] code);
		if (sel[1] || cfg == clk_switch_pkg::CFG_INT_OSC)
			return class_of(code);
		return clk_switch_pkg::SRC_EXT;
	endfunction

	// Index 0 of the chain is the high oscillator itself, index k its divide-by-2^k.
	function automatic logic level_of(input clk_switch_pkg::src_t s, input logic [3:0] code,
		input logic ext, input logic lf, input logic [clk_switch_pkg::DIV_W:0] chain);
		logic [3:0] idx;
		idx = (code >= clk_switch_pkg::FREQ_HF_TOP) ? 4'h0 : 4'(clk_switch_pkg::FREQ_HF_TOP - code);
		case (s)
			clk_switch_pkg::SRC_EXT: return ext;
			clk_switch_pkg::SRC_LF: return lf;
			clk_switch_pkg::SRC_PLL: return chain[0];
			default: return chain[idx];
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Input synchronisers and oscillator divider
	// ----------------------------------------------------------------
	logic [4:0] pins_s;
	logic ext_s;
	logic lf_s;
	logic hf_s;
	logic [1:0] cfg_s;
	logic hf_prev_r;
	logic [clk_switch_pkg::DIV_W-1:0] div_r, div_nxt;

	pin_sync #(.WIDTH(5)) u_sync (
		.clk(clk),
		.reset_n(reset_n),
		.din({cfg_osc_select, high_freq_osc_in, low_freq_osc_in, ext_clk_pin}),
		.dout(pins_s)
	);
	assign ext_s = pins_s[0];
	assign lf_s = pins_s[1];
	assign hf_s = pins_s[2];
	assign cfg_s = pins_s[4:3];

	// Sampling at 25 MHz limits how faithfully fast sources are followed.
	always_comb begin
		div_nxt = div_r;
		if (hf_s && !hf_prev_r)
			div_nxt = div_r + clk_switch_pkg::DIV_W'(1);
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			hf_prev_r <= 1'b0;
			div_r <= '0;
		end else begin
			hf_prev_r <= hf_s;
			div_r <= div_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Register slave
	// ----------------------------------------------------------------
	logic [1:0] sel_r, sel_nxt;
	logic [3:0] freq_r, freq_nxt;
	logic [31:0] readdata_r, readdata_nxt;
	logic waitrequest_r, waitrequest_nxt;
	state_t state_r, state_nxt;
	clk_switch_pkg::src_t cur_src_r, cur_src_nxt;
	logic [1:0] cfg_r, cfg_nxt;

	always_comb begin
		sel_nxt = sel_r;
		freq_nxt = freq_r;
		readdata_nxt = readdata_r;
		waitrequest_nxt = waitrequest_r ? !(read || write) : 1'b1;
		if (read && waitrequest_r) begin
			readdata_nxt = '0;
			if (address == clk_switch_pkg::OSC_CTRL_ADDR) begin
				readdata_nxt[clk_switch_pkg::SEL_MSB:clk_switch_pkg::SEL_LSB] = sel_r;
				readdata_nxt[clk_switch_pkg::FREQ_MSB:clk_switch_pkg::FREQ_LSB] = freq_r;
			end else if (address == clk_switch_pkg::STATUS_ADDR) begin
				readdata_nxt[clk_switch_pkg::ST_SRC_MSB:clk_switch_pkg::ST_SRC_LSB] = cur_src_r;
				readdata_nxt[clk_switch_pkg::ST_BUSY] = state_r != ST_RUN;
				readdata_nxt[clk_switch_pkg::ST_CFG_MSB:clk_switch_pkg::ST_CFG_LSB] = cfg_r;
				readdata_nxt[clk_switch_pkg::ST_PLL] = cur_src_r == clk_switch_pkg::SRC_PLL;
			end
		end
		if (write && !waitrequest_r && byteenable[0] &&
			address == clk_switch_pkg::OSC_CTRL_ADDR) begin
			sel_nxt = writedata[clk_switch_pkg::SEL_MSB:clk_switch_pkg::SEL_LSB];
			freq_nxt = writedata[clk_switch_pkg::FREQ_MSB:clk_switch_pkg::FREQ_LSB];
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sel_r <= 2'h0;
			freq_r <= 4'h0;
			readdata_r <= 32'h0;
			waitrequest_r <= 1'b1;
		end else begin
			sel_r <= sel_nxt;
			freq_r <= freq_nxt;
			readdata_r <= readdata_nxt;
			waitrequest_r <= waitrequest_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Switch controller
	// ----------------------------------------------------------------
	switch_if sw();
	switch_timer u_timer (
		.clk(clk),
		.reset_n(reset_n),
		.sw(sw)
	);

	logic [3:0] cur_code_r, cur_code_nxt;
	logic [3:0] tgt_code_r, tgt_code_nxt;
	clk_switch_pkg::src_t tgt_src_r, tgt_src_nxt;
	clk_switch_pkg::src_t want_src;
	clk_switch_pkg::src_t start_src;
	logic [1:0] boot_cnt_r, boot_cnt_nxt;
	logic cur_valid_r, cur_valid_nxt;
	logic sys_clk_r, sys_clk_nxt;
	logic cur_prev_r, new_prev_r;
	logic busy_r, pll_en_r;
	logic cur_lvl, new_lvl;
	logic start, wake;
	logic [clk_switch_pkg::DIV_W:0] chain;

	assign chain = {div_r, hf_s};
	assign cur_lvl = level_of(cur_src_r, cur_code_r, ext_s, lf_s, chain);
	assign new_lvl = level_of(tgt_src_r, tgt_code_r, ext_s, lf_s, chain);
	assign want_src = pick_src(sel_r, cfg_r, freq_r);

	always_comb begin
		state_nxt = state_r;
		cur_src_nxt = cur_src_r;
		cur_code_nxt = cur_code_r;
		tgt_src_nxt = tgt_src_r;
		tgt_code_nxt = tgt_code_r;
		boot_cnt_nxt = boot_cnt_r;
		cfg_nxt = cfg_r;
		cur_valid_nxt = cur_valid_r;
		start = 1'b0;
		wake = 1'b0;
		start_src = want_src;
		sys_clk_nxt = cur_valid_r ? cur_lvl : 1'b0;
		case (state_r)
			ST_BOOT: begin
				sys_clk_nxt = 1'b0;
				boot_cnt_nxt = boot_cnt_r + 2'h1;
				if (boot_cnt_r == clk_switch_pkg::BOOT_WAIT) begin
					cfg_nxt = cfg_s;
					start_src = pick_src(sel_r, cfg_s, freq_r);
					start = 1'b1;
					wake = 1'b1;
					state_nxt = ST_WAIT;
				end
			end
			ST_RUN: begin
				if (sleep) begin
					sys_clk_nxt = sys_clk_r && cur_lvl;
					if (!sys_clk_r) begin
						cur_valid_nxt = 1'b0;
						state_nxt = ST_SLEEP;
					end
				end else if (want_src != cur_src_r ||
					(want_src != clk_switch_pkg::SRC_EXT && freq_r != cur_code_r)) begin
					start = 1'b1;
					state_nxt = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (sw.done)
					state_nxt = ST_SWAP;
			end
			ST_SWAP: begin
				if (!sys_clk_r && !new_lvl) begin
					sys_clk_nxt = 1'b0;
					cur_src_nxt = tgt_src_r;
					cur_code_nxt = tgt_code_r;
					cur_valid_nxt = 1'b1;
					state_nxt = ST_RUN;
				end
			end
			ST_SLEEP: begin
				sys_clk_nxt = 1'b0;
				if (!sleep) begin
					start = 1'b1;
					wake = 1'b1;
					state_nxt = ST_WAIT;
				end
			end
			default: state_nxt = ST_BOOT;
		endcase
		if (start) begin
			tgt_src_nxt = start_src;
			tgt_code_nxt = freq_r;
		end
	end

	// Delay plan for the switch being started.
	always_comb begin
		sw.use_time = 1'b1;
		sw.cycles = clk_switch_pkg::SETTLE_CYC;
		sw.old_edges = 2'h0;
		sw.new_edges = 2'h0;
		if (wake && start_src == clk_switch_pkg::SRC_EXT) begin
			sw.use_time = 1'b0;
			sw.new_edges = clk_switch_pkg::WAKE_EXT_EDGES;
		end else if (wake) begin
			sw.cycles = clk_switch_pkg::CNT_W'(WARMUP_CYCLES);
		end else if (start_src == clk_switch_pkg::SRC_PLL && cur_src_r != clk_switch_pkg::SRC_PLL) begin
			sw.cycles = clk_switch_pkg::CNT_W'(PLL_LOCK_CYCLES);
		end else if (start_src == clk_switch_pkg::SRC_LF || start_src == clk_switch_pkg::SRC_EXT) begin
			sw.use_time = 1'b0;
			sw.old_edges = clk_switch_pkg::SWITCH_EDGES;
			sw.new_edges = clk_switch_pkg::SWITCH_EDGES;
		end
	end

	assign sw.start = start;
	assign sw.old_rise = cur_lvl && !cur_prev_r;
	assign sw.new_rise = new_lvl && !new_prev_r;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= ST_BOOT;
			cur_src_r <= clk_switch_pkg::SRC_EXT;
			cur_code_r <= 4'h0;
			tgt_src_r <= clk_switch_pkg::SRC_EXT;
			tgt_code_r <= 4'h0;
			boot_cnt_r <= 2'h0;
			cfg_r <= clk_switch_pkg::CFG_EXT_LOW;
			cur_valid_r <= 1'b0;
			sys_clk_r <= 1'b0;
			cur_prev_r <= 1'b0;
			new_prev_r <= 1'b0;
			busy_r <= 1'b1;
			pll_en_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cur_src_r <= cur_src_nxt;
			cur_code_r <= cur_code_nxt;
			tgt_src_r <= tgt_src_nxt;
			tgt_code_r <= tgt_code_nxt;
			boot_cnt_r <= boot_cnt_nxt;
			cfg_r <= cfg_nxt;
			cur_valid_r <= cur_valid_nxt;
			sys_clk_r <= sys_clk_nxt;
			cur_prev_r <= cur_lvl;
			new_prev_r <= new_lvl;
			busy_r <= state_nxt != ST_RUN;
			pll_en_r <= tgt_src_nxt == clk_switch_pkg::SRC_PLL ||
				cur_src_nxt == clk_switch_pkg::SRC_PLL;
		end
	end

	assign readdata = readdata_r;
	assign waitrequest = waitrequest_r;
	assign sys_clk = sys_clk_r;
	assign ext_power_mode = cfg_r;
	assign active_source = cur_src_r;
	assign switch_busy = busy_r;
	assign pll_enable = pll_en_r;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	a_sel_boot_clear: assert property (state_r == ST_BOOT && boot_cnt_r == 2'h0 |-> sel_r == 2'h0)
		else $error("select not clear after reset");
	a_cfg_capture: assert property (state_r == ST_BOOT && boot_cnt_r == 2'h2 |=>
		cfg_r == $past(cfg_s) && ext_power_mode == $past(cfg_s))
		else $error("configuration not captured");
	a_default_ext: assert property (start && sel_r == 2'h0 &&
		state_r == ST_RUN && cfg_r != 2'h3 |-> start_src == clk_switch_pkg::SRC_EXT)
		else $error("default source not external");
	a_select_int: assert property (start && sel_r[1] |->
		start_src != clk_switch_pkg::SRC_EXT)
		else $error("select 1x did not pick internal");
	a_ext_direct: assert property (state_r == ST_RUN && !sleep && cur_valid_r &&
		cur_src_r == clk_switch_pkg::SRC_EXT |=> sys_clk_r == $past(ext_s))
		else $error("external clock not passed directly");
	a_swap_glitch: assert property (cur_src_r != $past(cur_src_r) |->
		!sys_clk_r && !$past(sys_clk_r))
		else $error("source changed with clock high");
	a_sleep_low: assert property (state_r == ST_SLEEP |-> !sys_clk_r ##1 !sys_clk_r)
		else $error("clock running in sleep");
	a_lf_edges: assert property (start && !wake && start_src == clk_switch_pkg::SRC_LF |->
		!sw.use_time && sw.old_edges == 2'h1 && sw.new_edges == 2'h1)
		else $error("low oscillator switch plan wrong");
	a_pll_lock: assert property (start && !wake && start_src == clk_switch_pkg::SRC_PLL &&
		cur_src_r != clk_switch_pkg::SRC_PLL |-> sw.cycles == 16'(PLL_LOCK_CYCLES) ##1 pll_enable)
		else $error("multiplier lock wait wrong");
	a_wake_ext: assert property (start && wake && start_src == clk_switch_pkg::SRC_EXT |->
		sw.new_edges == 2'h2 && sw.old_edges == 2'h0)
		else $error("wake to external not two cycles");

	c_to_pll: cover property (state_r == ST_SWAP ##1 cur_src_r == clk_switch_pkg::SRC_PLL);
	c_wake: cover property (state_r == ST_SLEEP ##1 state_r == ST_WAIT);
	c_to_lf: cover property (state_r == ST_SWAP ##1 cur_src_r == clk_switch_pkg::SRC_LF);
	c_reg_write: cover property (write && !waitrequest);
endmodule

// ===== tb/osc_sources.sv
// Behavioural external clock source and internal oscillators.
`timescale 1ns/1ps
module osc_sources (
	input wire logic slow_ext,
	output logic ext_clk_pin,
	output logic low_freq_osc_in,
	output logic high_freq_osc_in
);
	// ----------------------------------------------------------------
	// Free-running sources
	// ----------------------------------------------------------------
	// The slow setting lets the bench see a late answer from the pin.
	initial ext_clk_pin = 1'b0;
	always #(slow_ext ? 780 : 260) ext_clk_pin = ~ext_clk_pin;
	initial low_freq_osc_in = 1'b0;
	always #1500 low_freq_osc_in = ~low_freq_osc_in;
	initial high_freq_osc_in = 1'b0;
	always #100 high_freq_osc_in = ~high_freq_osc_in;
endmodule

// ===== tb/system_clock_source_switch_tb.sv
// Self-checking bench for the system clock source switch.
`timescale 1ns/1ps
module system_clock_source_switch_tb;
	localparam int LOCK = 200;
	localparam int WARM = 25;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [1:0] cfg_osc_select = clk_switch_pkg::CFG_EXT_HIGH;
	logic sleep = 1'b0;
	logic slow_ext = 1'b0;
	logic [3:0] address = 4'h0;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [3:0] byteenable = 4'hf;
	logic ext_clk_pin;
	logic low_freq_osc_in;
	logic high_freq_osc_in;
	logic [31:0] readdata;
	logic waitrequest;
	logic sys_clk;
	logic switch_busy;
	logic pll_enable;
	logic [1:0] ext_power_mode;
	logic [2:0] active_source;
	int bad_count = 0;
	int checks = 0;
	int n;
	logic [7:0] lfsr_r = 8'h2b;
	logic [2:0] src_m;
	logic [1:0] sel_m;
	logic [3:0] code_m;
	logic [31:0] rd;

	always #20 clk = ~clk;

	osc_sources sources (.slow_ext(slow_ext), .ext_clk_pin(ext_clk_pin),
		.low_freq_osc_in(low_freq_osc_in), .high_freq_osc_in(high_freq_osc_in));

	system_clock_source_switch #(.PLL_LOCK_CYCLES(LOCK), .WARMUP_CYCLES(WARM)) dut (
		.clk(clk), .reset_n(reset_n), .cfg_osc_select(cfg_osc_select),
		.ext_clk_pin(ext_clk_pin), .low_freq_osc_in(low_freq_osc_in),
		.high_freq_osc_in(high_freq_osc_in), .sleep(sleep), .address(address),
		.read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest), .sys_clk(sys_clk),
		.ext_power_mode(ext_power_mode), .active_source(active_source),
		.switch_busy(switch_busy), .pll_enable(pll_enable));

	// ----------------------------------------------------------------
	// Reference model
	// ----------------------------------------------------------------
	function automatic logic [7:0] lfsr_next(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	function automatic logic [2:0] want_src(input logic [1:0] sel, input logic [1:0] cfg,
		input logic [3:0] code);
		if (!sel[1] && cfg != clk_switch_pkg::CFG_INT_OSC)
			return clk_switch_pkg::SRC_EXT;
		if (code == 4'h0)
			return clk_switch_pkg::SRC_LF;
		if (code <= 4'h7)
			return clk_switch_pkg::SRC_MF;
		if (code <= 4'hd)
			return clk_switch_pkg::SRC_HF;
		return clk_switch_pkg::SRC_PLL;
	endfunction

	// Shortest legal wait; the design may take longer while it waits for both levels low.
	function automatic int min_wait(input logic [2:0] from, input logic [2:0] to);
		if (to == clk_switch_pkg::SRC_PLL && from != clk_switch_pkg::SRC_PLL)
			return LOCK;
		if (to == clk_switch_pkg::SRC_MF || to == clk_switch_pkg::SRC_HF)
			return int'(clk_switch_pkg::SETTLE_CYC);
		if (to == clk_switch_pkg::SRC_PLL)
			return int'(clk_switch_pkg::SETTLE_CYC);
		return 2;
	endfunction

	// ----------------------------------------------------------------
	// Checks and bus cycles
	// ----------------------------------------------------------------
	task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic cmp_min(input string what, input int lo, input int got);
		checks++;
		if (got < lo) begin
			bad_count++;
			$display("BAD %s expected at least %0d seen %0d", what, lo, got);
		end
	endtask

	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] be);
		int k;
		k = 0;
		@(posedge clk);
		read <= !wr;
		write <= wr;
		address <= a;
		writedata <= d;
		byteenable <= be;
		// No cycle limit here: only the watchdog ends a wait that never gets an answer.
		do begin
			@(posedge clk);
			k++;
		end while (waitrequest !== 1'b0);
		cmp_word("bus answer", 32'h2, k);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask

	task automatic wait_busy(input logic v, input int lim);
		int k;
		k = 0;
		while (switch_busy !== v && k < lim) begin
			@(posedge clk);
			k++;
		end
		n += k;
		cmp_min("busy wait margin", 1, lim - k);
	endtask

	task automatic reset_check();
		cmp_word("reset outputs", 32'h60, {25'h0, waitrequest, switch_busy, sys_clk,
			pll_enable, active_source});
		cmp_word("reset readdata", 32'h0, readdata);
	endtask

	task automatic check_state();
		cmp_word("active source", {29'h0, src_m}, {29'h0, active_source});
		cmp_word("multiplier enable", {31'h0, src_m == clk_switch_pkg::SRC_PLL},
			{31'h0, pll_enable});
		bus(1'b0, clk_switch_pkg::STATUS_ADDR, 32'h0, 4'hf);
		cmp_word("status", {25'h0, src_m == clk_switch_pkg::SRC_PLL, cfg_osc_select, 1'b0,
			src_m}, rd & 32'h7f);
		bus(1'b0, clk_switch_pkg::OSC_CTRL_ADDR, 32'h0, 4'hf);
		cmp_word("control", {25'h0, code_m, 1'b0, sel_m}, rd & 32'h7b);
	endtask

	task automatic switch_to(input logic [1:0] sel, input logic [3:0] code);
		logic [2:0] nxt;
		lfsr_r = lfsr_next(lfsr_r);
		bus(1'b1, clk_switch_pkg::OSC_CTRL_ADDR, {lfsr_r, 16'h0, lfsr_r[0], code, lfsr_r[1],
			sel}, 4'hf);
		nxt = want_src(sel, cfg_osc_select, code);
		n = 0;
		wait_busy(1'b1, 10);
		wait_busy(1'b0, 3000);
		cmp_min("switch delay", min_wait(src_m, nxt), n);
		src_m = nxt;
		sel_m = sel;
		code_m = code;
		check_state();
	endtask

	task automatic tally_and_finish();
		if (bad_count == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		repeat (8) @(posedge clk);
		reset_check();
		reset_n <= 1'b1;
		src_m = clk_switch_pkg::SRC_EXT;
		sel_m = 2'h0;
		code_m = 4'h0;
		n = 0;
		wait_busy(1'b0, 500);
		cmp_min("boot delay", 12, n);
		cmp_word("power range", {30'h0, clk_switch_pkg::CFG_EXT_HIGH},
			{30'h0, ext_power_mode});
		check_state();
		bus(1'b1, 4'h8, 32'hffffffff, 4'hf);
		bus(1'b0, 4'h8, 32'h0, 4'hf);
		cmp_word("unmapped read", 32'h0, rd);
		bus(1'b1, clk_switch_pkg::STATUS_ADDR, 32'hffffffff, 4'hf);
		bus(1'b1, clk_switch_pkg::OSC_CTRL_ADDR, 32'h0000007a, 4'he);
		check_state();
		for (int i = 0; i < 16; i++)
			switch_to(2'h2, 4'(i));
		sleep <= 1'b1;
		wait_busy(1'b1, 10);
		repeat (4) @(posedge clk);
		n = 0;
		repeat (40) @(posedge clk)
			n += int'(sys_clk !== 1'b0);
		cmp_word("clock in sleep", 32'h0, n);
		sleep <= 1'b0;
		n = 0;
		wait_busy(1'b0, 3000);
		cmp_min("wake delay", WARM, n);
		check_state();
		switch_to(2'h2, 4'h0);
		slow_ext <= 1'b1;
		switch_to(2'h0, 4'h0);
		n = 0;
		repeat (100) @(posedge clk)
			n += int'(sys_clk === 1'b1);
		cmp_min("clock high time", 30, n);
		cmp_min("clock low time", 30, 100 - n);
		// Leave a non-zero select and a switch in flight so that the reset has work to undo.
		bus(1'b1, clk_switch_pkg::OSC_CTRL_ADDR, 32'h0000004b, 4'hf);
		bus(1'b0, clk_switch_pkg::OSC_CTRL_ADDR, 32'h0, 4'hf);
		cmp_word("control pending", 32'h4b, rd);
		reset_n <= 1'b0;
		cfg_osc_select <= clk_switch_pkg::CFG_INT_OSC;
		repeat (2) @(posedge clk);
		reset_check();
		reset_n <= 1'b1;
		src_m = want_src(2'h0, clk_switch_pkg::CFG_INT_OSC, 4'h0);
		sel_m = 2'h0;
		code_m = 4'h0;
		n = 0;
		@(posedge clk);
		wait_busy(1'b0, 500);
		cmp_min("power-up internal", WARM, n);
		check_state();
		tally_and_finish();
	end

	initial begin
		repeat (40000) @(posedge clk);
		bad_count++;
		tally_and_finish();
	end
endmodule
